// ===== dv/tb_upw_pwm_unit.sv
// Self-checking bench for the up-counting PWM unit
`timescale 1ns/10ps
module tb_upw_pwm_unit
	import upw_pkg::*;
;
	typedef struct {logic [2:0] rate; logic [15:0] per; logic [15:0] duty;} upw_row_t;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic        cpu_idle = 1'b0;
	logic        irq;
	logic        wake_req;
	logic [3:0]  pin_out;
	int          mismatches = 0;
	int          check_count = 0;
	int          h;
	int          l;
	int          dv;
	// One row per rate code: rate, period, duty never above period
	upw_row_t    rows [8] = '{'{3'h0, 16'h0002, 16'h0001}, '{3'h1, 16'h0003, 16'h0001},
		'{3'h2, 16'h0003, 16'h0002}, '{3'h3, 16'h0005, 16'h0002},
		'{3'h4, 16'h0004, 16'h0003}, '{3'h5, 16'h0006, 16'h0001},
		'{3'h6, 16'h0007, 16'h0004}, '{3'h7, 16'h0004, 16'h0002}};

	// 250 MHz clock
	always #2 clock = ~clock;

	upw_pwm_unit u_upw_pwm_unit (
		.clock     (clock),
		.rst_n     (rst_n),
		.reg_addr  (reg_addr),
		.reg_wdata (reg_wdata),
		.reg_wr    (reg_wr),
		.reg_rd    (reg_rd),
		.reg_rdata (reg_rdata),
		.cpu_idle  (cpu_idle),
		.irq       (irq),
		.wake_req  (wake_req),
		.pin_out   (pin_out)
	);

	// ****************************************
	// Helper tasks
	// ****************************************
	task automatic finish_test;
		if (mismatches == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Step past an edge so its updates have landed
	task automatic tick;
		@(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe
	task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clock);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk($sformatf("reg %0d", a), reg_rdata, exp);
	endtask

	// Bounded wait for masked pin levels, n counts the cycles spent
	task automatic wpin(input logic [3:0] e, input logic [3:0] m, input int lim, output int n);
		n = 0;
		while ((pin_out & m) !== e) begin
			tick();
			n++;
			if (n > lim) begin
				chk("pin wait", {12'h000, pin_out}, {12'h000, e});
				finish_test();
			end
		end
	endtask

	task automatic do_reset;
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		tick();
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		do_reset();
		chk("pins", {12'h000, pin_out}, 16'h0000);
		for (int a = 0; a < 10; a++) begin
			rdc(a[3:0], 16'h0000);
		end
		wr(UPW_ADDR_COUNT, 16'h1234);
		wr(4'h9, 16'h5678);
		rdc(UPW_ADDR_COUNT, 16'h0000);
		rdc(4'h9, 16'h0000);
		wr(UPW_ADDR_GPIO_OUT, 16'h000e);
		wr(UPW_ADDR_CHSEL, 16'h0001);
		tick();
		chk("pins", {12'h000, pin_out}, 16'h000e);
		// Table of rates: cycle length and high time on channel 0
		foreach (rows[i]) begin
			dv = 1 << (7 - rows[i].rate);
			wr(UPW_ADDR_PERIOD, rows[i].per);
			wr(UPW_ADDR_DUTY, rows[i].duty);
			wr(UPW_ADDR_CTRL, {8'h00, 1'b1, rows[i].rate, 4'h0});
			tick();
			chk("sync", {15'h0000, pin_out[0]}, 16'h0000);
			wpin(4'h1, 4'h1, 8, h);
			wpin(4'h0, 4'h1, 2000, h);
			wpin(4'h1, 4'h1, 2000, h);
			wpin(4'h0, 4'h1, 2000, h);
			wpin(4'h1, 4'h1, 2000, l);
			chk("cycle", 16'(h + l), 16'(rows[i].per * dv));
			chk("high", 16'(h >= rows[i].duty * dv && h <= (rows[i].duty + 1) * dv), 16'h0001);
			chk("gpio", {13'h0000, pin_out[3:1]}, 16'h0007);
			wr(UPW_ADDR_CTRL, 16'h0000);
			tick();
			wpin(4'he, 4'hf, 8, h);
		end
		// Overflow flag, interrupt mask and idle wake
		chk("irq", {15'h0000, irq}, 16'h0000);
		rdc(UPW_ADDR_STATUS, 16'h0001);
		wr(UPW_ADDR_IRQ_MASK, 16'h0001);
		tick();
		tick();
		chk("irq", {15'h0000, irq}, 16'h0001);
		chk("wake", {15'h0000, wake_req}, 16'h0000);
		@(posedge clock);
		cpu_idle <= 1'b1;
		tick();
		tick();
		chk("wake", {15'h0000, wake_req}, 16'h0001);
		wr(UPW_ADDR_STATUS, 16'h0001);
		tick();
		tick();
		chk("irq", {15'h0000, irq}, 16'h0000);
		rdc(UPW_ADDR_STATUS, 16'h0000);
		// Deselect a running channel, then reset in mid-run
		wr(UPW_ADDR_GPIO_OUT, 16'h0001);
		wr(UPW_ADDR_PERIOD, 16'h0008);
		wr(UPW_ADDR_DUTY, 16'h0004);
		wr(UPW_ADDR_CTRL, 16'h00f0);
		tick();
		wpin(4'h0, 4'h1, 40, h);
		wr(UPW_ADDR_CHSEL, 16'h0000);
		tick();
		wpin(4'h1, 4'hf, 8, h);
		do_reset();
		chk("pins", {12'h000, pin_out}, 16'h0000);
		rdc(UPW_ADDR_CTRL, 16'h0000);
		rdc(UPW_ADDR_STATUS, 16'h0000);
		// Single pulse: one high phase, then run bit cleared by hardware
		wr(UPW_ADDR_PERIOD, 16'h0004);
		wr(UPW_ADDR_DUTY, 16'h0002);
		wr(UPW_ADDR_CHSEL, 16'h0001);
		wr(UPW_ADDR_CTRL, 16'h00f1);
		tick();
		wpin(4'h1, 4'h1, 8, h);
		wpin(4'h0, 4'h1, 20, h);
		l = 0;
		repeat (40) begin
			tick();
			l += (pin_out[0] !== 1'b0);
		end
		chk("pulses", 16'(l), 16'h0000);
		rdc(UPW_ADDR_CTRL, 16'h0071);
		rdc(UPW_ADDR_STATUS, 16'h0001);
		finish_test();
	end
endmodule

// ===== hw/upw_pkg.sv
// Package of constants for the up-counting PWM unit
package upw_pkg;
	// ************************************************
	// Register map (word index on the plain port)
	// ************************************************
	localparam logic [3:0] UPW_ADDR_CTRL     = 4'h0;
	localparam logic [3:0] UPW_ADDR_CHSEL    = 4'h1;
	localparam logic [3:0] UPW_ADDR_PERIOD   = 4'h2;
	localparam logic [3:0] UPW_ADDR_DUTY     = 4'h3;
	localparam logic [3:0] UPW_ADDR_COUNT    = 4'h4;
	localparam logic [3:0] UPW_ADDR_STATUS   = 4'h5;
	localparam logic [3:0] UPW_ADDR_IRQ_MASK = 4'h6;
	localparam logic [3:0] UPW_ADDR_GPIO_OUT = 4'h7;
	// ************************************************
	// Field positions
	// ************************************************
	localparam int UPW_CTRL_RUN_BIT    = 7;
	localparam int UPW_CTRL_RATE_LSB   = 4;
	localparam int UPW_CTRL_SINGLE_BIT = 0;
	localparam int UPW_STAT_OVF_BIT    = 0;
	// ************************************************
	// Reset values and counts
	// ************************************************
	localparam logic [7:0]  UPW_CTRL_RST   = 8'h00;
	localparam logic [15:0] UPW_WORD_RST   = 16'h0000;
	localparam logic [6:0]  UPW_PRESC_MAX  = 7'h7f;
	localparam int          UPW_NUM_CH     = 4;
	localparam int          UPW_SYNC_STAGES = 2;
endpackage

// ===== hw/upw_pwm_unit.sv
// Up-counting four-channel PWM unit with plain register port
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
// ************************************************
// Functional notes
// ************************************************
//
// Functional notes
// - One 16-bit up-counter drives all four output channels.
// - At the period boundary the counter clears and the overflow flag is set.
// - Single-pulse mode stops the unit after the first cycle.
// - A pin carries PWM only while its channel-select bit is set.
// - Clearing a select bit returns the pin to its last GPIO level.
// - With its interrupt enabled the unit can wake the core from idle.
// - Step from period-1 to period sets overflow flag at once; flag read/writable.
// - Counter clocked from oscillator through prescaler, 3-bit rate, 1 to 128.
// - Rate code 000 divides by 128, each step halves, 111 divides by 1.
// - Overflow reaches the interrupt line only while its enable bit is set.
// - Pin switches to PWM only after output synchronisation completes.
// - On start or return to zero the PWM output is high.
// - Cycle length is taken from the period register.
// - Output goes low when counter equals duty value.
// - On overflow counter restarts from zero and output goes high.
// - After single pulse, hardware clears run enable and pins return to idle.
// ************************************************
// Register map (word index on the plain port)
// ************************************************
// 0 control: [7] run enable, [6:4] rate select, [0] single pulse, others stored
// 1 channel select: [3:0], one bit for each shared pin
// 2 period limit, 3 duty value, both 16 bits
// 4 counter, read only; writes are dropped
// 5 status: [0] overflow flag, write one to clear, a new overflow wins
// 6 interrupt mask: [0] overflow interrupt enable
// 7 gpio levels: [3:0], shown while a pin is not on the waveform
// Unmapped indices read zero and ignore writes
// A zero period never starts the counter, so the pins stay on GPIO
module upw_pwm_unit
	import upw_pkg::*;
#(
	parameter int CH = UPW_NUM_CH
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	input  wire logic        cpu_idle,
	output logic             irq,
	output logic             wake_req,
	output logic [CH-1:0]    pin_out
);

	logic [7:0]    ctrl_r;
	logic [CH-1:0] chsel_r;
	logic [15:0]   period_limit_r;
	logic [15:0]   duty_value_r;
	logic [15:0]   pwm_counter_r;
	logic          overflow_flag_r;
	logic          overflow_irq_enable_r;
	logic [CH-1:0] gpio_out_r;
	logic [6:0]    presc_r;
	logic          pwm_level_r;
	logic [UPW_SYNC_STAGES-1:0] sync_r;
	logic          running_r;

	logic          run_enable;
	logic [2:0]    rate_divider_sel;
	logic          single_pulse_enable;
	logic          tick;
	logic          ovf_step;
	logic          wr_ctrl;
	logic          wr_stat;

	assign run_enable          = ctrl_r[UPW_CTRL_RUN_BIT];
	assign rate_divider_sel    = ctrl_r[UPW_CTRL_RATE_LSB +: 3];
	assign single_pulse_enable = ctrl_r[UPW_CTRL_SINGLE_BIT];
	assign wr_ctrl             = reg_wr && (reg_addr == UPW_ADDR_CTRL);
	assign wr_stat             = reg_wr && (reg_addr == UPW_ADDR_STATUS);

	// ************************************************
	// Prescaler
	// ************************************************
	// Divide mask: code 7 gives mask 0 (every cycle), code 0 gives 127
	function automatic logic [6:0] div_mask(input logic [2:0] code);
		div_mask = UPW_PRESC_MAX >> code;
	endfunction

	// Free count of oscillator cycles while running
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			presc_r <= 7'h00;
		end else if (!running_r) begin
			presc_r <= 7'h00;
		end else begin
			presc_r <= presc_r + 7'h01;
		end
	end

	// One tick per divided period
	assign tick = running_r && ((presc_r & div_mask(rate_divider_sel)) == div_mask(rate_divider_sel));
	assign ovf_step = tick && (pwm_counter_r == period_limit_r - 16'h0001);

	// ************************************************
	// Control register and run enable
	// ************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r <= UPW_CTRL_RST;
		end else if (ovf_step && single_pulse_enable) begin
			ctrl_r[UPW_CTRL_RUN_BIT] <= 1'b0;
		end else if (wr_ctrl) begin
			ctrl_r <= reg_wdata[7:0];
		end
	end

	// Other software registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			chsel_r               <= '0;
			period_limit_r        <= UPW_WORD_RST;
			duty_value_r          <= UPW_WORD_RST;
			overflow_irq_enable_r <= 1'b0;
			gpio_out_r            <= '0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				UPW_ADDR_CHSEL:    chsel_r <= reg_wdata[CH-1:0];
				UPW_ADDR_PERIOD:   period_limit_r <= reg_wdata;
				UPW_ADDR_DUTY:     duty_value_r <= reg_wdata;
				UPW_ADDR_IRQ_MASK: overflow_irq_enable_r <= reg_wdata[0];
				UPW_ADDR_GPIO_OUT: gpio_out_r <= reg_wdata[CH-1:0];
				default: ;
			endcase
		end
	end

	// ************************************************
	// Counter and waveform
	// ************************************************
	// Running follows run enable; a zero period never starts
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			running_r <= 1'b0;
		end else begin
			running_r <= run_enable && (period_limit_r != 16'h0000) && !(ovf_step && single_pulse_enable);
		end
	end

	// Single 16-bit up counter, cleared at the boundary
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pwm_counter_r <= UPW_WORD_RST;
		end else if (!running_r) begin
			pwm_counter_r <= UPW_WORD_RST;
		end else if (ovf_step) begin
			pwm_counter_r <= UPW_WORD_RST;
		end else if (tick) begin
			pwm_counter_r <= pwm_counter_r + 16'h0001;
		end
	end

	// High at start and on each restart, low at duty match
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pwm_level_r <= 1'b1;
		end else if (!running_r || ovf_step) begin
			pwm_level_r <= 1'b1;
		end else if (pwm_counter_r == duty_value_r) begin
			pwm_level_r <= 1'b0;
		end
	end

	// Output synchronisation before the pins take the waveform
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sync_r <= '0;
		end else begin
			sync_r <= {sync_r[UPW_SYNC_STAGES-2:0], running_r};
		end
	end

	// ************************************************
	// Pin sharing
	// ************************************************
	// Each pin: PWM when selected and synchronised, else last GPIO level
	for (genvar g = 0; g < CH; g++) begin : g_pin
		always_ff @(posedge clock or negedge rst_n) begin
			if (!rst_n) begin
				pin_out[g] <= 1'b0;
			end else if (chsel_r[g] && sync_r[UPW_SYNC_STAGES-1] && running_r) begin
				pin_out[g] <= pwm_level_r;
			end else begin
				pin_out[g] <= gpio_out_r[g];
			end
		end
	end

	// ************************************************
	// Flag, interrupt and wake
	// ************************************************
	// Set wins over a write-one clear; writable by firmware
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			overflow_flag_r <= 1'b0;
		end else if (ovf_step) begin
			overflow_flag_r <= 1'b1;
		end else if (wr_stat && reg_wdata[UPW_STAT_OVF_BIT]) begin
			overflow_flag_r <= 1'b0;
		end
	end

	// Masked level interrupt and idle wake
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			irq      <= 1'b0;
			wake_req <= 1'b0;
		end else begin
			irq      <= overflow_flag_r && overflow_irq_enable_r;
			wake_req <= overflow_flag_r && overflow_irq_enable_r && cpu_idle;
		end
	end

	// ************************************************
	// Read port
	// ************************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				UPW_ADDR_CTRL:     reg_rdata <= {8'h00, ctrl_r};
				UPW_ADDR_CHSEL:    reg_rdata <= 16'(chsel_r);
				UPW_ADDR_PERIOD:   reg_rdata <= period_limit_r;
				UPW_ADDR_DUTY:     reg_rdata <= duty_value_r;
				UPW_ADDR_COUNT:    reg_rdata <= pwm_counter_r;
				UPW_ADDR_STATUS:   reg_rdata <= {15'h0000, overflow_flag_r};
				UPW_ADDR_IRQ_MASK: reg_rdata <= {15'h0000, overflow_irq_enable_r};
				UPW_ADDR_GPIO_OUT: reg_rdata <= 16'(gpio_out_r);
				default:           reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	AST_OVF_SETS_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
		ovf_step |=> overflow_flag_r)
		else $error("overflow did not set flag");
	AST_WRAP_TO_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
		ovf_step |=> pwm_counter_r == 16'h0000)
		else $error("counter did not clear at boundary");
	AST_SINGLE_STOPS: assert property (@(posedge clock) disable iff (!rst_n)
		(ovf_step && single_pulse_enable) |=> !run_enable ##1 !running_r)
		else $error("single pulse did not stop");
	AST_IRQ_GATED: assert property (@(posedge clock) disable iff (!rst_n)
		!overflow_irq_enable_r |=> !irq)
		else $error("irq without enable");
	AST_DUTY_LOW: assert property (@(posedge clock) disable iff (!rst_n)
		(running_r && !ovf_step && pwm_counter_r == duty_value_r) |=> !pwm_level_r)
		else $error("no low at duty match");
	AST_RESTART_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
		ovf_step |=> pwm_level_r)
		else $error("no high after restart");
	AST_GPIO_DESEL: assert property (@(posedge clock) disable iff (!rst_n)
		!chsel_r[0] |=> pin_out[0] == $past(gpio_out_r[0]))
		else $error("deselected pin not gpio");
	AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(running_r) |=> pin_out == $past(gpio_out_r))
		else $error("pin switched before sync");
	AST_COUNT_BOUND: assert property (@(posedge clock) disable iff (!rst_n)
		running_r |-> pwm_counter_r < period_limit_r)
		else $error("counter beyond period");

	// ************************************************
	// Checks of counting, pins and read port
	// ************************************************
	// Counter steps once per tick and holds between ticks
	AST_COUNT_STEP: assert property (@(posedge clock) disable iff (!rst_n)
		(running_r && tick && !ovf_step) |=> pwm_counter_r == $past(pwm_counter_r) + 16'h0001)
		else $error("counter did not step on tick");
	AST_COUNT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
		(running_r && !tick) |=> pwm_counter_r == $past(pwm_counter_r))
		else $error("counter moved without tick");
	AST_RATE_FULL: assert property (@(posedge clock) disable iff (!rst_n)
		(running_r && rate_divider_sel == 3'h7) |-> tick)
		else $error("undivided rate missed a tick");
	AST_RATE_SLOW: assert property (@(posedge clock) disable iff (!rst_n)
		(tick && rate_divider_sel == 3'h0) |-> presc_r == UPW_PRESC_MAX)
		else $error("slowest rate ticked early");
	AST_ZERO_PERIOD: assert property (@(posedge clock) disable iff (!rst_n)
		(period_limit_r == 16'h0000) |=> !running_r)
		else $error("zero period started");
	AST_STOP_CLEARS: assert property (@(posedge clock) disable iff (!rst_n)
		!running_r |=> pwm_counter_r == 16'h0000)
		else $error("stopped counter not zero");
	AST_START_HIGH: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(running_r) |-> pwm_level_r)
		else $error("waveform not high at start");
	// Pins follow the waveform only when selected and synchronised
	AST_PWM_PIN: assert property (@(posedge clock) disable iff (!rst_n)
		(chsel_r[0] && sync_r[UPW_SYNC_STAGES-1] && running_r) |=> pin_out[0] == $past(pwm_level_r))
		else $error("selected pin not on waveform");
	AST_NONE_SELECTED: assert property (@(posedge clock) disable iff (!rst_n)
		(chsel_r == '0) |=> pin_out == $past(gpio_out_r))
		else $error("unselected pins not gpio");
	AST_STOPPED_GPIO: assert property (@(posedge clock) disable iff (!rst_n)
		!running_r |=> pin_out == $past(gpio_out_r))
		else $error("stopped unit still drives pins");
	// Flag, interrupt and wake follow their sources one cycle later
	AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
		(wr_stat && reg_wdata[UPW_STAT_OVF_BIT] && !ovf_step) |=> !overflow_flag_r)
		else $error("flag not cleared by write");
	AST_IRQ_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
		(overflow_flag_r && overflow_irq_enable_r) |=> irq)
		else $error("enabled flag gave no irq");
	AST_WAKE_FOLLOWS: assert property (@(posedge clock) disable iff (!rst_n)
		(overflow_flag_r && overflow_irq_enable_r && cpu_idle) |=> wake_req)
		else $error("idle core not woken");
	AST_WAKE_GATED: assert property (@(posedge clock) disable iff (!rst_n)
		!cpu_idle |=> !wake_req)
		else $error("wake while core busy");
	// Read data stands one cycle after the strobe, zero otherwise
	AST_RDATA_IDLE: assert property (@(posedge clock) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data without strobe");
	AST_RDATA_CTRL: assert property (@(posedge clock) disable iff (!rst_n)
		(reg_rd && reg_addr == UPW_ADDR_CTRL) |=> reg_rdata == {8'h00, $past(ctrl_r)})
		else $error("control read back wrong");
	COV_OVF: cover property (@(posedge clock) disable iff (!rst_n) ovf_step);
	COV_PIN_PWM: cover property (@(posedge clock) disable iff (!rst_n) chsel_r[0] && running_r);
	COV_SINGLE: cover property (@(posedge clock) disable iff (!rst_n)
		ovf_step && single_pulse_enable);
	COV_IRQ: cover property (@(posedge clock) disable iff (!rst_n) irq);
	COV_WAKE: cover property (@(posedge clock) disable iff (!rst_n) wake_req);

endmodule
